// ===== hdl/gss_pkg.sv
`default_nettype none
package gss_pkg;

  // apb register map, one aligned word each
  localparam int APB_AW = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_INFO = 8'h0c;

  // reset values
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [7:0] MODE_RST = 8'h00;

  // mode of operation that selects gear slave behaviour (-3)
  localparam logic [7:0] MODE_GEAR = 8'hfd;

  // control word values
  localparam logic [15:0] CW_DISABLE = 16'h0000;
  localparam logic [15:0] CW_SHUTDOWN = 16'h0006;
  localparam logic [15:0] CW_SWITCH_ON = 16'h0007;
  localparam logic [15:0] CW_ENABLE = 16'h000f;
  localparam logic [15:0] CW_GEAR_STD = 16'h001f;
  localparam logic [15:0] CW_GEAR_DIR = 16'h005f;
  localparam logic [15:0] CW_CORR = 16'h003f;
  localparam logic [11:0] CW_PH_STD_LOW = 12'h21f;
  localparam logic [11:0] CW_PH_DIR_LOW = 12'h25f;
  localparam int CW_PROFILE_LSB = 12;
  localparam int CB_CORR = 5;

  // status word values and bit positions
  localparam logic [15:0] ST_SOD = 16'h0050;
  localparam logic [15:0] ST_RTSO = 16'h0031;
  localparam logic [15:0] ST_SWON = 16'h0033;
  localparam logic [15:0] ST_OPEN = 16'h0037;
  localparam logic [15:0] ST_GEAR_BASE = 16'h0027;
  localparam int SB_PHASED = 4;
  localparam int SB_DONE = 8;
  localparam int SB_GEAR_RUN = 9;
  localparam int SB_IN_GEAR = 10;
  localparam int SB_CORR_OK = 12;

  // power and motion states
  typedef enum logic [2:0] {
    S_SOD = 3'b000,
    S_RTSO = 3'b001,
    S_SWON = 3'b010,
    S_OPEN = 3'b011,
    S_GEAR = 3'b100
  } gss_state_e;

  // classified control word
  typedef enum logic [2:0] {
    CMD_NONE = 3'b000,
    CMD_DISABLE = 3'b001,
    CMD_SHUTDOWN = 3'b010,
    CMD_SWITCH_ON = 3'b011,
    CMD_ENABLE = 3'b100,
    CMD_GEAR = 3'b101,
    CMD_CORR = 3'b110
  } gss_cmd_e;

endpackage
`default_nettype wire

// ===== hdl/gss_ctrl_decode.sv
`default_nettype none
module gss_ctrl_decode
  import gss_pkg::*;
(
  input wire logic [15:0] ctrl_word,
  output var gss_cmd_e cmd,
  output logic direct_sync,
  output logic phase_en,
  output logic [1:0] profile
);

  // pure classification; anything not listed is CMD_NONE
  always_comb begin
    cmd = CMD_NONE;
    direct_sync = 1'b0;
    phase_en = 1'b0;
    profile = ctrl_word[CW_PROFILE_LSB +: 2];
    case (ctrl_word)
      CW_DISABLE: cmd = CMD_DISABLE;
      CW_SHUTDOWN: cmd = CMD_SHUTDOWN;
      CW_SWITCH_ON: cmd = CMD_SWITCH_ON;
      CW_ENABLE: cmd = CMD_ENABLE;
      CW_GEAR_STD: cmd = CMD_GEAR;
      CW_CORR: cmd = CMD_CORR;
      CW_GEAR_DIR: begin
        cmd = CMD_GEAR;
        direct_sync = 1'b1;
      end
      default: begin
        // top nibble picks one of four phasing profiles
        if (ctrl_word[15:14] == 2'b00 && ctrl_word[11:0] == CW_PH_STD_LOW) begin
          cmd = CMD_GEAR;
          phase_en = 1'b1;
        end else if (ctrl_word[15:14] == 2'b00 && ctrl_word[11:0] == CW_PH_DIR_LOW) begin
          cmd = CMD_GEAR;
          direct_sync = 1'b1;
          phase_en = 1'b1;
        end
      end
    endcase
  end

endmodule
`default_nettype wire

// ===== hdl/gss_sequencer.sv
// Implementation choices: the register addresses and register access over APB.
`default_nettype none
// Summary of operation
// - disable gives 0x0050; three-step sequence enables
// - mode -3 selects gear slave behaviour
// - 0x0006/0x0007/0x000F walk power states
// - 0x001F starts standard gear coupling
// - 0x005F starts coupling with direct sync
// - 0xp21F couples with phasing profile p
// - 0xp25F direct sync with phasing profile
// - uncoupled status 0xn327 then 0xn337
// - coupled status 0xn727 then 0xn737
// - 0x001F to 0x003F starts position correction
// - motion changes only while operation enabled; the code also starts gear coupling from switched on in mode -3
// - 0x0007 stops motion; enable pattern restarts
// - mode change safe under 0x0007, restart
// - clearing bit 5 aborts running correction
// - status bit 10 shows slave in gear
// - bit 12 clear during correction, set done
module gss_sequencer
  import gss_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic in_gear,
  input wire logic phasing_done,
  input wire logic corr_done,
  output logic drive_enable,
  output logic gear_run,
  output logic gear_start,
  output logic gear_direct_sync,
  output logic phasing_enable,
  output logic [1:0] phasing_profile,
  output logic corr_start,
  output logic corr_abort,
  output logic [15:0] status_word
);

  typedef struct packed {
    gss_state_e state;
    logic [15:0] ctrl;
    logic [7:0] mode;
    logic gear_mode;
    logic direct;
    logic phase_en;
    logic [1:0] profile;
    logic ph_ok;
    logic corr_busy;
    logic corr_ok;
    logic [15:0] status;
    logic [31:0] prdata;
    logic drive_en;
    logic gear_run;
    logic gear_start;
    logic corr_start;
    logic corr_abort;
  } gss_regs_s;

  gss_regs_s r_reg;
  gss_regs_s r_next;

  gss_cmd_e cmd;
  logic cmd_direct;
  logic cmd_phase_en;
  logic [1:0] cmd_profile;
  logic wr_access;
  logic rd_setup;
  logic addr_hit;
  logic ctrl_wr;
  logic ph_set;
  logic ph_clr;
  logic corr_set;
  logic corr_clr;
  logic [15:0] status_calc;

  // the written word itself is classified, so a command acts at its own write edge
  gss_ctrl_decode i_gss_ctrl_decode (
    .ctrl_word(pwdata[15:0]),
    .cmd(cmd),
    .direct_sync(cmd_direct),
    .phase_en(cmd_phase_en),
    .profile(cmd_profile)
  );

  // apb decode; zero wait states so pready is simply high
  assign addr_hit = (paddr == OFF_CTRL) || (paddr == OFF_MODE) ||
                    (paddr == OFF_STATUS) || (paddr == OFF_INFO);
  assign wr_access = psel && penable && pwrite && addr_hit;
  assign rd_setup = psel && !penable && !pwrite;
  assign ctrl_wr = wr_access && (paddr == OFF_CTRL);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_hit;

  // status word built from the present state; it is registered below,
  // which makes it trail any state change by exactly one cycle
  always_comb begin
    status_calc = ST_SOD;
    case (r_reg.state)
      S_SOD: status_calc = ST_SOD;
      S_RTSO: status_calc = ST_RTSO;
      S_SWON: status_calc = ST_SWON;
      S_OPEN: begin
        status_calc = ST_OPEN;
        status_calc[SB_CORR_OK] = r_reg.corr_ok;
      end
      S_GEAR: begin
        status_calc = ST_GEAR_BASE;
        status_calc[SB_GEAR_RUN] = 1'b1;
        // no profile chosen means nothing to phase
        status_calc[SB_PHASED] = !r_reg.phase_en || r_reg.ph_ok;
        status_calc[SB_IN_GEAR] = in_gear;
        // bit 8 drops while a correction runs, as it reports the last started function
        status_calc[SB_DONE] = !r_reg.corr_busy;
        status_calc[SB_CORR_OK] = r_reg.corr_ok && !r_reg.corr_busy;
      end
      default: status_calc = ST_SOD;
    endcase
  end

  // next-state logic for the whole block
  always_comb begin
    r_next = r_reg;
    r_next.gear_start = 1'b0;
    r_next.corr_start = 1'b0;
    r_next.corr_abort = 1'b0;
    r_next.status = status_calc;
    ph_clr = 1'b0;
    corr_set = 1'b0;
    corr_clr = 1'b0;

    // mode is only stored here; it takes effect at the next enable or gear word from switched on
    if (wr_access && paddr == OFF_MODE) begin
      r_next.mode = pwdata[7:0];
    end

    if (ctrl_wr) begin
      r_next.ctrl = pwdata[15:0];

      // dropping bit 5 cancels the correction whatever else the word says
      if (r_reg.corr_busy && !pwdata[CB_CORR]) begin
        r_next.corr_busy = 1'b0;
        r_next.corr_abort = 1'b1;
      end

      case (cmd)
        CMD_DISABLE: begin
          r_next.state = S_SOD;
        end
        CMD_SHUTDOWN: begin
          // accepted from every state, disabled included
          r_next.state = S_RTSO;
        end
        CMD_SWITCH_ON: begin
          // from any enabled state this halts the motion
          if (r_reg.state == S_RTSO || r_reg.state == S_OPEN || r_reg.state == S_GEAR) begin
            r_next.state = S_SWON;
          end
        end
        CMD_ENABLE: begin
          if (r_reg.state == S_SWON) begin
            // mode is latched here, so a change made under 0x0007 is safe
            r_next.gear_mode = (r_reg.mode == MODE_GEAR);
            r_next.state = S_OPEN;
          end else if (r_reg.state == S_GEAR) begin
            r_next.state = S_OPEN;
          end
        end
        CMD_GEAR: begin
          // restart after a halt uses the mode latched now
          if (r_reg.state == S_SWON) begin
            r_next.gear_mode = (r_reg.mode == MODE_GEAR);
          end
          if ((r_reg.state == S_SWON && r_reg.mode == MODE_GEAR) ||
              ((r_reg.state == S_OPEN || r_reg.state == S_GEAR) && r_reg.gear_mode)) begin
            r_next.state = S_GEAR;
            r_next.direct = cmd_direct;
            r_next.phase_en = cmd_phase_en;
            r_next.profile = cmd_profile;
            r_next.gear_start = 1'b1;
            ph_clr = 1'b1;
          end
        end
        CMD_CORR: begin
          // only from a plain standard coupling, and only once in gear
          if (r_reg.state == S_GEAR && r_reg.ctrl == CW_GEAR_STD && in_gear && !r_reg.corr_busy) begin
            r_next.corr_busy = 1'b1;
            r_next.corr_start = 1'b1;
            corr_clr = 1'b1;
          end
        end
        default: begin
          // unknown words update the stored control word and, with bit 5 clear, end a running correction
          r_next.state = r_reg.state;
        end
      endcase
    end

    // correction finished by the motion engine
    if (r_reg.corr_busy && corr_done && !r_next.corr_abort && !r_next.corr_start) begin
      r_next.corr_busy = 1'b0;
      corr_set = 1'b1;
    end

    // leaving the coupled state ends a running correction
    if (r_next.state != S_GEAR && r_next.corr_busy) begin
      r_next.corr_busy = 1'b0;
      r_next.corr_abort = 1'b1;
    end

    // sticky done flags; a set in the clearing cycle wins
    ph_set = r_reg.gear_run && r_reg.phase_en && phasing_done;
    r_next.ph_ok = (r_reg.ph_ok && !ph_clr) || ph_set;
    r_next.corr_ok = (r_reg.corr_ok && !corr_clr) || corr_set;

    // outputs to the motion engine follow the next state
    r_next.drive_en = (r_next.state == S_OPEN) || (r_next.state == S_GEAR);
    r_next.gear_run = (r_next.state == S_GEAR);

    // read data is captured in the setup phase, valid through access
    if (rd_setup) begin
      case (paddr)
        OFF_CTRL: r_next.prdata = {16'h0000, r_reg.ctrl};
        OFF_MODE: r_next.prdata = {24'h000000, r_reg.mode};
        OFF_STATUS: r_next.prdata = {16'h0000, r_reg.status};
        OFF_INFO: r_next.prdata = {20'h00000, r_reg.state, r_reg.gear_mode, r_reg.direct,
                                   r_reg.phase_en, r_reg.profile, r_reg.ph_ok,
                                   r_reg.corr_busy, r_reg.corr_ok, 1'b0};
        default: r_next.prdata = 32'h00000000;
      endcase
    end
  end

  // single register bank; reset gives switch-on disabled
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      r_reg <= '0;
      r_reg.state <= S_SOD;
      r_reg.ctrl <= CTRL_RST;
      r_reg.mode <= MODE_RST;
      r_reg.status <= ST_SOD;
    end else begin
      r_reg <= r_next;
    end
  end

  // port drive straight from flip-flops
  assign prdata = r_reg.prdata;
  assign drive_enable = r_reg.drive_en;
  assign gear_run = r_reg.gear_run;
  assign gear_start = r_reg.gear_start;
  assign gear_direct_sync = r_reg.direct;
  assign phasing_enable = r_reg.phase_en;
  assign phasing_profile = r_reg.profile;
  assign corr_start = r_reg.corr_start;
  assign corr_abort = r_reg.corr_abort;
  assign status_word = r_reg.status;

endmodule
`default_nettype wire

// ===== tb/gss_plc_model.sv
`default_nettype none
module gss_plc_model
  import gss_pkg::*;
(
  input wire logic sys_clk,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [APB_AW-1:0] paddr,
  output logic [31:0] pwdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // request held until pready is seen at an edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d; // stale data must not look valid once released
  endtask
  // mode is only touched once switched on is confirmed
  task automatic set_mode(input logic [7:0] m);
    logic [31:0] q;
    logic e;
    xfer(1'b0, OFF_STATUS, 32'h0, q, e);
    if (q[7:0] == 8'h33) xfer(1'b1, OFF_MODE, {24'h0, m}, q, e);
  endtask
endmodule
`default_nettype wire

// ===== tb/gss_seq_sva.sv
`default_nettype none
module gss_seq_chk
  import gss_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  input wire logic in_gear,
  input wire logic drive_enable,
  input wire logic gear_run,
  input wire logic gear_start,
  input wire logic corr_start,
  input wire logic [15:0] status_word
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // control write at the edge the slave takes it
  sequence s_wr(logic [15:0] v);
    psel && penable && pwrite && paddr == OFF_CTRL && pwdata[15:0] == v;
  endsequence
  sequence s_stop;
    !drive_enable && !gear_run ##1 status_word == 16'h0033;
  endsequence
  a_disable_st: assert property (s_wr(16'h0000) |-> ##2 status_word == 16'h0050)
    else $error("disable status wrong");
  a_shutdown_st: assert property (s_wr(16'h0006) |-> ##2 status_word == 16'h0031)
    else $error("shutdown status wrong");
  a_switch_stop: assert property (s_wr(16'h0007) && drive_enable |-> ##1 s_stop)
    else $error("motion not stopped");
  a_gear_pulse: assert property (gear_start |-> gear_run ##1 !gear_start)
    else $error("gear start pulse wrong");
  a_coupled_st: assert property (gear_run && in_gear |=> status_word[10] && status_word[9])
    else $error("coupled status wrong");
  a_uncoupled_st: assert property (gear_run && !in_gear |=> !status_word[10] && status_word[9])
    else $error("uncoupled status wrong");
  a_corr_gate: assert property (corr_start |-> $past(in_gear) && gear_run)
    else $error("correction started out of gear");
  a_corr_busy: assert property (corr_start |=> !status_word[12] && !status_word[8])
    else $error("busy correction status wrong");
  a_unmapped_err: assert property (psel && penable && paddr > OFF_INFO |-> pslverr)
    else $error("unmapped access not refused");
endmodule
bind gss_sequencer gss_seq_chk i_chk (.sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .in_gear(in_gear),
  .drive_enable(drive_enable), .gear_run(gear_run), .gear_start(gear_start), .corr_start(corr_start),
  .status_word(status_word));
`default_nettype wire

// ===== tb/tb_gear_slave_control_sequencer.sv
`default_nettype none
module tb_gear_slave_control_sequencer
  import gss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic md; logic [15:0] cw; logic [15:0] st; logic [15:0] mk; logic [2:0] dp;} gss_row_s;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic in_gear = 1'b0;
  logic phasing_done = 1'b0;
  logic corr_done = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, drive_enable, gear_run, gear_start, dsync, corr_start, corr_abort, pe;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] status_word;
  logic [1:0] prof;
  logic e, gs, cs, ca;
  int bad_count = 0;
  int checks = 0;
  // md: set mode -3 first; dp: {direct sync, profile}
  gss_row_s rows [21] = '{
    '{0, 16'h0000, 16'h0050, 16'hffff, 0}, '{0, 16'h001f, 16'h0050, 16'hffff, 0},
    '{0, 16'h0006, 16'h0031, 16'hffff, 0}, '{0, 16'h0007, 16'h0033, 16'hffff, 0},
    '{0, 16'h001f, 16'h0033, 16'hffff, 0}, '{0, 16'h000f, 16'h0037, 16'hffff, 0},
    '{0, 16'h001f, 16'h0037, 16'hffff, 0}, '{0, 16'h0007, 16'h0033, 16'hffff, 0},
    '{1, 16'h000f, 16'h0037, 16'hffff, 0}, '{0, 16'h001f, 16'h0327, 16'hffef, 0},
    '{0, 16'h0007, 16'h0033, 16'hffff, 0}, '{0, 16'h000f, 16'h0037, 16'hffff, 0},
    '{0, 16'h005f, 16'h0327, 16'hffef, 4}, '{0, 16'h021f, 16'h0327, 16'hffff, 0},
    '{0, 16'h121f, 16'h0327, 16'hffff, 1}, '{0, 16'h221f, 16'h0327, 16'hffff, 2},
    '{0, 16'h321f, 16'h0327, 16'hffff, 3}, '{0, 16'h025f, 16'h0327, 16'hffff, 4},
    '{0, 16'h125f, 16'h0327, 16'hffff, 5}, '{0, 16'h225f, 16'h0327, 16'hffff, 6},
    '{0, 16'h325f, 16'h0327, 16'hffff, 7}};
  gss_sequencer i_gss_sequencer (.sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .in_gear(in_gear), .phasing_done(phasing_done), .corr_done(corr_done), .drive_enable(drive_enable),
    .gear_run(gear_run), .gear_start(gear_start), .gear_direct_sync(dsync), .phasing_enable(pe),
    .phasing_profile(prof), .corr_start(corr_start), .corr_abort(corr_abort), .status_word(status_word));
  gss_plc_model i_plc (.sys_clk(sys_clk), .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  always #2 sys_clk = ~sys_clk;
  task automatic chk(input string n, input logic [15:0] x, input logic [15:0] y);
    checks++;
    if (y !== x) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, x, y);
    end
  endtask
  // write control, catch the pulses, let status settle
  // pulses stand only in the cycle right after the write edge
  task automatic cw(input logic [15:0] v);
    i_plc.xfer(1'b1, OFF_CTRL, {16'h0, v}, q, e);
    #1;
    gs = gear_start;
    cs = corr_start;
    ca = corr_abort;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  // one input pulse, then two edges for status to follow
  task automatic pulse_wait(input int k);
    @(posedge sys_clk);
    if (k == 0) phasing_done <= 1'b1;
    else corr_done <= 1'b1;
    @(posedge sys_clk);
    phasing_done <= 1'b0;
    corr_done <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge sys_clk);
    bad_count++;
    complete_run();
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    resetn <= 1'b1;
    #1;
    chk("reset status", 16'h0050, status_word);
    chk("reset enable", 0, drive_enable);
    i_plc.xfer(1'b0, OFF_MODE, 32'h0, q, e);
    chk("mode reset", 0, q[15:0]);
    i_plc.xfer(1'b0, 8'h10, 32'h0, q, e);
    chk("unmapped err", 1, e);
    $display("test reset done");
    foreach (rows[i]) begin
      if (rows[i].md) i_plc.set_mode(MODE_GEAR);
      cw(rows[i].cw);
      chk("row status", rows[i].st & rows[i].mk, status_word & rows[i].mk);
      chk("row enable", rows[i].st[2], drive_enable);
      chk("row run", rows[i].st[9], gear_run);
      if (rows[i].st[9]) chk("row phase en", rows[i].cw[9], pe);
      if (rows[i].st[9]) chk("row sync prof", rows[i].dp, {dsync, prof});
      if (rows[i].st[9]) chk("row start", 1, gs);
    end
    $display("test rows done");
    pulse_wait(0);
    chk("phased", 16'h0337, status_word);
    @(posedge sys_clk);
    in_gear <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("coupled", 16'h0737, status_word);
    i_plc.xfer(1'b0, OFF_STATUS, 32'h0, q, e);
    chk("status read", 16'h0737, q[15:0]);
    chk("mapped err", 0, e);
    cw(16'h1234);
    chk("refused", 16'h0737, status_word);
    $display("test phasing done");
    // no master motion is modelled, so the master counts as stationary
    cw(16'h001f);
    cw(16'h003f);
    chk("corr start", 1, cs);
    chk("corr busy", 16'h0637, status_word);
    pulse_wait(1);
    chk("corr ok", 16'h1737, status_word);
    cw(16'h001f);
    cw(16'h003f);
    cw(16'h001f);
    chk("corr abort", 1, ca);
    cw(16'h005f);
    cw(16'h003f);
    chk("no corr", 0, cs);
    $display("test correction done");
    // halt, then restart straight from switched on
    cw(16'h0007);
    cw(16'h001f);
    chk("restart start", 1, gs);
    chk("restart status", 16'h0737, status_word);
    $display("test restart done");
    // second reset in mid-run, while coupled
    @(posedge sys_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    #1;
    chk("rerun status", 16'h0050, status_word);
    chk("rerun enable", 0, drive_enable);
    i_plc.xfer(1'b0, OFF_MODE, 32'h0, q, e);
    chk("rerun mode", 0, q[15:0]);
    $display("test reset again done");
    complete_run();
  end
endmodule
`default_nettype wire
